// file: hw/rco_consts.vh
// constants for the reference clock output block
`ifndef RCO_CONSTS_VH
`define RCO_CONSTS_VH
// register byte offsets
`define RCO_OFF_CTRL_LOW 12'h000
`define RCO_OFF_CTRL_HIGH 12'h004
`define RCO_OFF_OSC_CTRL 12'h008
`define RCO_OFF_CONFIG 12'h00c
// control low field positions
`define RCO_BIT_ENABLE 15
`define RCO_BIT_STOP_IDLE 13
`define RCO_BIT_PIN_DRIVE 12
`define RCO_BIT_RUN_SLEEP 11
`define RCO_BIT_SWITCH_REQ 9
`define RCO_BIT_ACTIVE 8
// source select codes
`define RCO_SRC_OSC 4'h0
`define RCO_SRC_SYS_HALF 4'h1
`define RCO_SRC_PRIMARY 4'h2
`define RCO_SRC_FAST_RC 4'h3
`define RCO_SRC_LP_RC 4'h4
`define RCO_SRC_SECONDARY 4'h5
`define RCO_SRC_PLL 4'h6
`define RCO_SRC_EXT_PIN 4'h8
// config word field positions
`define RCO_CFG_PLL_SPLIT 4
`define RCO_CFG_SEC_PIN_SEL 3
`define RCO_CFG_SEC_DRIVE 8
`define RCO_CFG_AUX_OUT 9
`define RCO_CFG_PRESCALE_LSB 0
`define RCO_CFG_CORE_DIV_LSB 10
`define RCO_CFG_SEC_FORCE 12
// oscillator switch unlock keys
`define RCO_KEY_HIGH_1 8'h78
`define RCO_KEY_HIGH_2 8'h9a
`define RCO_KEY_LOW_1 8'h46
`define RCO_KEY_LOW_2 8'h57
// reset values
`define RCO_RST_DIVISOR 15'h0001
`define RCO_RST_CONFIG 16'h0018
`endif

// file: hw/rco_half_divider.v
// divides a one-cycle enable rate into a square half-period divider
`timescale 1ns/1ns
module rco_half_divider #(
   parameter WIDTH = 15
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // control
   input wire run,
   input wire tick,
   input wire [WIDTH-1:0] divisor,
   input wire load_req,
   // results
   output reg out_ff,
   output reg loaded_ff
);
   reg [WIDTH-1:0] cnt_ff;
   reg [WIDTH-1:0] div_ff;
   wire at_end;
   wire period_edge;

   // a full period ends when the output is low and the count expires
   assign at_end = (cnt_ff == {WIDTH{1'b0}});
   assign period_edge = at_end && !out_ff;

   // half-period counter, new divisor at a period boundary, or at once while stopped or when the current divisor is zero
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= {WIDTH{1'b0}};
         div_ff <= {WIDTH{1'b0}};
         out_ff <= 1'b0;
         loaded_ff <= 1'b0;
      end else begin
         loaded_ff <= 1'b0;
         if (!run) begin
            // stopped: no pulse can be cut, so the divisor applies at once
            out_ff <= 1'b0;
            cnt_ff <= {WIDTH{1'b0}};
            div_ff <= divisor;
            if (load_req) begin
               loaded_ff <= 1'b1;
            end
         end else if (tick) begin
            if (div_ff == {WIDTH{1'b0}}) begin
               out_ff <= ~out_ff;
            end else if (at_end) begin
               out_ff <= ~out_ff;
               cnt_ff <= div_ff - {{(WIDTH-1){1'b0}}, 1'b1};
            end else begin
               cnt_ff <= cnt_ff - {{(WIDTH-1){1'b0}}, 1'b1};
            end
            if (load_req && (period_edge || div_ff == {WIDTH{1'b0}})) begin
               div_ff <= divisor;
               cnt_ff <= divisor - {{(WIDTH-1){1'b0}}, 1'b1};
               loaded_ff <= 1'b1;
            end
         end
      end
   end
endmodule

// file: hw/rco_ref_clock_out.v
// reference clock output generator with its apb control registers
`timescale 1ns/1ns
`include "rco_consts.vh"
module rco_ref_clock_out #(
   parameter DIV_WIDTH = 15
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   // source clock enables, one-cycle pulses from async sources
   input wire [8:0] src_tick_async,
   // device power state and peripheral requests
   input wire idle_mode,
   input wire sleep_mode,
   input wire sec_osc_request,
   // pins
   output reg ref_clock_pin_ff,
   output wire ref_clock_pin_oe,
   output reg aux_clock_out_pin_ff,
   output wire sec_osc_run,
   output wire sec_osc_low_power,
   output wire sec_osc_pins_digital,
   // oscillator switch and clock chain settings
   output reg osc_switch_go_ff,
   output reg [2:0] osc_new_source_ff,
   output reg [3:0] pll_prescale_div_ff,
   output reg [3:0] core_clock_div_ff,
   output wire pll_for_ref_only
);
   reg [15:0] ctrl_ff;
   reg [DIV_WIDTH-1:0] divisor_ff;
   reg [15:0] config_ff;
   reg switch_req_ff;
   reg [1:0] unlock_ff;
   reg [8:0] tick_s1_ff;
   reg [8:0] tick_s2_ff;
   reg [8:0] tick_s3_ff;
   reg aux_div_ff;
   reg active_ff;
   // divider bypass, go window and the chosen source level
   reg bypass_ff;
   reg low_open_ff;
   reg sel_level;
   reg sel_prev;
   wire sel_tick;
   wire go_write;
   wire wr_en;
   wire run;
   wire div_out;
   wire div_loaded;
   wire [3:0] src_sel;
   wire [1:0] core_sel;
   wire [7:0] wbyte_hi;
   wire [7:0] wbyte_lo;

   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en = psel && penable && pwrite;
   assign src_sel = ctrl_ff[3:0];
   assign wbyte_hi = pwdata[15:8];
   assign wbyte_lo = pwdata[7:0];
   assign core_sel = config_ff[`RCO_CFG_CORE_DIV_LSB+1:`RCO_CFG_CORE_DIV_LSB];

   // switch-go strobe: a write with bit 0 set right after the low key pair
   assign go_write = wr_en && paddr == `RCO_OFF_OSC_CTRL && low_open_ff
      && pwdata[0];

   // generator runs when enabled and not halted by idle or sleep
   assign run = ctrl_ff[`RCO_BIT_ENABLE]
      && !(idle_mode && ctrl_ff[`RCO_BIT_STOP_IDLE])
      && !(sleep_mode && !ctrl_ff[`RCO_BIT_RUN_SLEEP]);

   assign ref_clock_pin_oe = ctrl_ff[`RCO_BIT_PIN_DRIVE] && active_ff;
   assign pll_for_ref_only = !config_ff[`RCO_CFG_PLL_SPLIT];
   assign sec_osc_pins_digital = !config_ff[`RCO_CFG_SEC_PIN_SEL];
   assign sec_osc_low_power = !config_ff[`RCO_CFG_SEC_DRIVE];
   assign sec_osc_run = config_ff[`RCO_CFG_SEC_PIN_SEL]
      && (sec_osc_request || config_ff[`RCO_CFG_SEC_FORCE]
      || (run && src_sel == `RCO_SRC_SECONDARY));

   // synchronise source ticks; edge of the second stage is the enable
   // sources must run below half the clock rate or edges are lost
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_s1_ff <= 9'h000;
         tick_s2_ff <= 9'h000;
         tick_s3_ff <= 9'h000;
      end else begin
         tick_s1_ff <= src_tick_async;
         tick_s2_ff <= tick_s1_ff;
         tick_s3_ff <= tick_s2_ff;
      end
   end

   // source select mux; codes 0-6 sit on tick lanes of the same number,
   // the input pin on lane 8; reserved codes give a flat low level
   always @* begin
      sel_level = 1'b0;
      sel_prev = 1'b0;
      case (src_sel)
         `RCO_SRC_OSC, `RCO_SRC_SYS_HALF, `RCO_SRC_PRIMARY,
         `RCO_SRC_FAST_RC, `RCO_SRC_LP_RC, `RCO_SRC_SECONDARY,
         `RCO_SRC_PLL: begin
            sel_level = tick_s2_ff[src_sel[2:0]];
            sel_prev = tick_s3_ff[src_sel[2:0]];
         end
         `RCO_SRC_EXT_PIN: begin
            sel_level = tick_s2_ff[8];
            sel_prev = tick_s3_ff[8];
         end
         default: begin
            sel_level = 1'b0;
            sel_prev = 1'b0;
         end
      endcase
   end

   // one enable pulse per rising edge of the chosen source level
   assign sel_tick = sel_level & ~sel_prev;

   // half-period divider with boundary-aligned divisor loads
   rco_half_divider #(
      .WIDTH(DIV_WIDTH)
   ) u_div (
      .clk(clk),
      .rst_n(rst_n),
      .run(run),
      .tick(sel_tick),
      .divisor(divisor_ff),
      .load_req(switch_req_ff),
      .out_ff(div_out),
      .loaded_ff(div_loaded)
   );

   // pin output, active status and aux half-rate clock
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_clock_pin_ff <= 1'b0;
         active_ff <= 1'b0;
         aux_div_ff <= 1'b0;
         aux_clock_out_pin_ff <= 1'b0;
      end else begin
         // a zero divisor passes the source level itself, at full rate
         ref_clock_pin_ff <= (bypass_ff ? sel_level & run : div_out)
            & ctrl_ff[`RCO_BIT_PIN_DRIVE];
         active_ff <= run;
         if (tick_s2_ff[0] & ~tick_s3_ff[0]) begin
            aux_div_ff <= ~aux_div_ff;
         end
         aux_clock_out_pin_ff <= aux_div_ff
            & config_ff[`RCO_CFG_AUX_OUT];
      end
   end

   // bypass follows a zero divisor: taken at once while stopped, and
   // otherwise when the divider reports that a switch has landed
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bypass_ff <= 1'b0;
      end else if (!run || div_loaded) begin
         bypass_ff <= (divisor_ff == {DIV_WIDTH{1'b0}});
      end
   end

   // pll prescale and core divider decode
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pll_prescale_div_ff <= 4'h1;
         core_clock_div_ff <= 4'h1;
      end else begin
         case (config_ff[`RCO_CFG_PRESCALE_LSB+3:`RCO_CFG_PRESCALE_LSB])
            4'h6: pll_prescale_div_ff <= 4'h8;
            4'h7: pll_prescale_div_ff <= 4'hc;
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5:
               pll_prescale_div_ff <= config_ff[3:0] + 4'h1;
            default: pll_prescale_div_ff <= 4'hc;
         endcase
         case (core_sel)
            2'h0: core_clock_div_ff <= 4'h1;
            2'h1: core_clock_div_ff <= 4'h2;
            2'h2: core_clock_div_ff <= 4'h4;
            default: core_clock_div_ff <= 4'h8;
         endcase
      end
   end

   // register writes and switch handshake; software set wins over hardware clear
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= 16'h0000;
         divisor_ff <= `RCO_RST_DIVISOR;
         config_ff <= `RCO_RST_CONFIG;
         switch_req_ff <= 1'b0;
         unlock_ff <= 2'h0;
         osc_switch_go_ff <= 1'b0;
         osc_new_source_ff <= 3'h0;
      end else begin
         osc_switch_go_ff <= go_write;
         if (div_loaded) begin
            switch_req_ff <= 1'b0;
         end
         if (wr_en && paddr == `RCO_OFF_CTRL_LOW) begin
            ctrl_ff <= {pwdata[15], 1'b0, pwdata[13:11], 7'h00,
               pwdata[3:0]};
            if (pwdata[`RCO_BIT_SWITCH_REQ]) begin
               switch_req_ff <= 1'b1;
            end
         end
         if (wr_en && paddr == `RCO_OFF_CTRL_HIGH) begin
            divisor_ff <= pwdata[DIV_WIDTH-1:0];
         end
         if (wr_en && paddr == `RCO_OFF_CONFIG) begin
            config_ff <= pwdata[15:0];
         end
         // unlock: 0 idle, 1 first high key, 2 high open, 3 low key seen
         if (wr_en && paddr == `RCO_OFF_OSC_CTRL) begin
            case (unlock_ff)
               2'h0: unlock_ff <= (wbyte_hi == `RCO_KEY_HIGH_1) ? 2'h1
                  : (wbyte_lo == `RCO_KEY_LOW_1) ? 2'h3 : 2'h0;
               2'h1: begin
                  if (wbyte_hi == `RCO_KEY_HIGH_2) begin
                     unlock_ff <= 2'h2;
                  end else begin
                     unlock_ff <= 2'h0;
                  end
               end
               2'h2: begin
                  osc_new_source_ff <= wbyte_hi[2:0];
                  unlock_ff <= 2'h0;
               end
               2'h3: begin
                  if (wbyte_lo == `RCO_KEY_LOW_2) begin
                     unlock_ff <= 2'h0;
                  end else begin
                     unlock_ff <= 2'h0;
                  end
               end
               default: unlock_ff <= 2'h0;
            endcase
         end
      end
   end

   // opens the go window once the second low key is written
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_open_ff <= 1'b0;
      end else if (wr_en && paddr == `RCO_OFF_OSC_CTRL) begin
         low_open_ff <= (unlock_ff == 2'h3)
            && (wbyte_lo == `RCO_KEY_LOW_2);
      end
   end

   // read data, latched in the setup cycle of a read
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            `RCO_OFF_CTRL_LOW: prdata <= {16'h0000, ctrl_ff[15:11], 1'b0,
               switch_req_ff, active_ff, 4'h0, ctrl_ff[3:0]};
            `RCO_OFF_CTRL_HIGH: prdata <= {17'h00000, divisor_ff};
            `RCO_OFF_OSC_CTRL: prdata <= {29'h00000000, osc_new_source_ff};
            `RCO_OFF_CONFIG: prdata <= {16'h0000, config_ff};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule

// file: verif/rco_ref_clock_out_assertions.sv
// concurrent checks on the reference clock output ports
`timescale 1ns/1ns
module rco_ref_clock_out_chk (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // apb
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   // power state
   input wire idle_mode,
   input wire sleep_mode,
   // watched outputs
   input wire ref_clock_pin_ff,
   input wire ref_clock_pin_oe,
   input wire sec_osc_low_power,
   input wire sec_osc_pins_digital,
   input wire [3:0] pll_prescale_div_ff,
   input wire [3:0] core_clock_div_ff,
   input wire pll_for_ref_only
);
   reg [15:0] ctl_ff;
   reg [15:0] cfg_ff;
   reg [2:0] off_cnt_ff;
   reg [2:0] idl_cnt_ff;
   reg [2:0] slp_cnt_ff;
   wire wr = psel & penable & pwrite;
   wire rd0 = psel & penable & ~pwrite & (paddr == 12'h000);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // saturating count of cycles a halt condition has held
   function automatic [2:0] bump(input h, input [2:0] c);
      bump = h ? c + {2'h0, ~&c} : 3'h0;
   endfunction
   // expected pll prescale ratio for codes below eight
   function automatic [3:0] pre(input [2:0] c);
      pre = (c < 3'h6) ? {1'b0, c} + 4'h1 : (c[0] ? 4'hc : 4'h8);
   endfunction
   // shadow of written control and config words
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_ff <= 16'h0000;
         cfg_ff <= 16'h0018;
         off_cnt_ff <= 3'h0;
         idl_cnt_ff <= 3'h0;
         slp_cnt_ff <= 3'h0;
      end else begin
         if (wr && paddr == 12'h000) ctl_ff <= pwdata[15:0];
         if (wr && paddr == 12'h00c) cfg_ff <= pwdata[15:0];
         off_cnt_ff <= bump(!ctl_ff[15], off_cnt_ff);
         idl_cnt_ff <= bump(idle_mode && ctl_ff[13], idl_cnt_ff);
         slp_cnt_ff <= bump(sleep_mode && !ctl_ff[11], slp_cnt_ff);
      end
   end
   AST_OE_GATE: assert property (
      !ctl_ff[12] && !$past(ctl_ff[12]) |-> !ref_clock_pin_oe)
      else $error("pin enabled with drive bit clear");
   AST_OFF_HALT: assert property (off_cnt_ff == 3'h7 |->
      $stable(ref_clock_pin_ff)) else $error("output moves while off");
   AST_IDLE_HALT: assert property (idl_cnt_ff == 3'h7 |->
      $stable(ref_clock_pin_ff)) else $error("output moves in idle");
   AST_SLEEP_HALT: assert property (slp_cnt_ff == 3'h7 |->
      $stable(ref_clock_pin_ff)) else $error("output moves in sleep");
   AST_ACTIVE_CLR: assert property (rd0 && off_cnt_ff == 3'h7 |->
      !prdata[8]) else $error("active flag set while off");
   AST_CORE_DIV: assert property (
      core_clock_div_ff == (4'h1 << $past(cfg_ff[11:10])))
      else $error("core divide ratio wrong");
   AST_PRESCALE: assert property (!$past(cfg_ff[3]) |->
      pll_prescale_div_ff == pre($past(cfg_ff[2:0])))
      else $error("prescale ratio wrong");
   AST_PINS_DIG: assert property (
      sec_osc_pins_digital == !cfg_ff[3]) else $error("pin mode wrong");
   AST_PLL_SPLIT: assert property (
      pll_for_ref_only == !cfg_ff[4]) else $error("pll split wrong");
   AST_LOW_POWER: assert property (
      sec_osc_low_power == !cfg_ff[8]) else $error("drive mode wrong");
endmodule
bind rco_ref_clock_out rco_ref_clock_out_chk chk_i (.clk, .rst_n, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .idle_mode, .sleep_mode,
   .ref_clock_pin_ff, .ref_clock_pin_oe, .sec_osc_low_power,
   .sec_osc_pins_digital, .pll_prescale_div_ff, .core_clock_div_ff,
   .pll_for_ref_only);

// file: verif/rco_ext_receiver.sv
// external device clocked from the reference output pin
`timescale 1ns/1ns
module rco_ext_receiver (
   // pin side
   input wire pin,
   input wire pin_oe,
   // observations
   output int edges,
   output int period_ns
);
   time last_t;
   // a released pin sits at the pull-down level
   wire line = pin_oe ? pin : 1'b0;
   initial begin
      edges = 0;
      period_ns = 0;
      last_t = 0;
   end
   // count rising edges and the time between the last two
   always @(posedge line) begin
      edges = edges + 1;
      period_ns = int'($time - last_t);
      last_t = $time;
   end
endmodule

// file: verif/testbench.sv
// register-level bench for the reference clock output block
`timescale 1ns/1ns
module testbench;
   reg clk, rst_n, psel, penable, pwrite, idle_mode, sleep_mode, sreq;
   reg [11:0] paddr;
   reg [31:0] pwdata;
   reg [8:0] src;
   reg [1:0] sdiv;
   wire pready, pslverr, pin, oe, aux, srun, slp, sdig, go, pfr;
   wire [31:0] prdata;
   wire [2:0] nsrc;
   wire [3:0] pdiv, cdiv;
   int bad_count, check_count, edges, period_ns, e0, i, go_count;
   logic [31:0] rd;
   logic [3:0] codes [8] = '{0, 1, 2, 3, 4, 5, 6, 8};
   rco_ref_clock_out dut (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .src_tick_async(src), .idle_mode(idle_mode), .sleep_mode(sleep_mode),
      .sec_osc_request(sreq), .ref_clock_pin_ff(pin), .ref_clock_pin_oe(oe),
      .aux_clock_out_pin_ff(aux), .sec_osc_run(srun),
      .sec_osc_low_power(slp), .sec_osc_pins_digital(sdig),
      .osc_switch_go_ff(go), .osc_new_source_ff(nsrc),
      .pll_prescale_div_ff(pdiv), .core_clock_div_ff(cdiv),
      .pll_for_ref_only(pfr));
   rco_ext_receiver far (.pin(pin), .pin_oe(oe), .edges(edges),
      .period_ns(period_ns));
   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // every source ticks once per four clocks, 32 ns
   always @(posedge clk) begin
      sdiv <= sdiv + 2'h1;
      src <= {9{sdiv[1]}};
   end
   // count one-cycle switch-go pulses
   always @(posedge clk) go_count <= go_count + int'(go === 1'b1);
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // one apb transfer, entered just after a rising edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task rdc(input logic [11:0] a, input logic [31:0] e, input string n);
      apb(1'b0, a, 32'h0);
      chk(n, e, rd);
   endtask
   task per(input int p);
      repeat (64) @(posedge clk);
      chk("period", p, period_ns);
   endtask
   task act(input logic e);
      repeat (8) @(posedge clk);
      e0 = edges;
      repeat (48) @(posedge clk);
      chk("toggling", {31'h0, e}, {31'h0, edges != e0});
   endtask
   // aux pin sampled away from the edge, then back in step
   task aux_on(input logic e);
      e0 = 0;
      repeat (32) begin
         @(negedge clk);
         e0 += aux;
      end
      @(posedge clk);
      chk("aux toggling", {31'h0, e}, {31'h0, e0 != 0});
   endtask
   // new divisor, request the switch, poll until it completes
   task sw(input logic [31:0] d);
      apb(1'b1, 12'h004, d);
      apb(1'b1, 12'h000, 32'h9200);
      rd = 32'h200;
      for (i = 0; i < 40 && rd[9] !== 1'b0; i++) apb(1'b0, 12'h000, 32'h0);
      chk("switch bit", 32'h0, {31'h0, rd[9]});
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // watchdog
   initial begin
      repeat (10000) @(posedge clk);
      bad_count++;
      end_of_test;
   end
   initial begin
      {rst_n, psel, penable, pwrite, idle_mode, sleep_mode, sreq} = 7'h0;
      {paddr, pwdata, src, sdiv} = 55'h0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      rdc(12'h000, 32'h0, "ctrl reset");
      rdc(12'h004, 32'h1, "divisor reset");
      rdc(12'h00c, 32'h18, "config reset");
      rdc(12'h010, 32'h0, "unmapped");
      apb(1'b1, 12'h000, 32'h9000);
      per(64);
      rdc(12'h000, 32'h9100, "active");
      sw(32'h3);
      per(192);
      sw(32'h0);
      per(32);
      sw(32'h2);
      foreach (codes[k]) begin
         apb(1'b1, 12'h000, 32'h0);
         apb(1'b1, 12'h000, {28'h0900, codes[k]});
         per(128);
         rdc(12'h000, {28'h0910, codes[k]}, "source");
      end
      apb(1'b1, 12'h000, 32'h8000);
      act(1'b0);
      rdc(12'h000, 32'h8100, "undriven");
      idle_mode <= 1'b1;
      apb(1'b1, 12'h000, 32'hb000);
      act(1'b0);
      apb(1'b1, 12'h000, 32'h9000);
      act(1'b1);
      idle_mode <= 1'b0;
      sleep_mode <= 1'b1;
      act(1'b0);
      apb(1'b1, 12'h000, 32'h9800);
      act(1'b1);
      sleep_mode <= 1'b0;
      apb(1'b1, 12'h000, 32'h1000);
      act(1'b0);
      rdc(12'h000, 32'h1000, "inactive");
      for (i = 0; i < 8; i++) begin
         apb(1'b1, 12'h00c, {20'h0, i[1:0], 1'b0, i[0], 5'h0, i[2:0]});
         @(posedge clk);
         chk("core div", 32'h1 << i[1:0], {28'h0, cdiv});
         chk("prescale", i < 6 ? i + 1 : (i == 6 ? 8 : 12), pdiv);
      end
      aux_on(1'b0);
      chk("osc run", 32'h0, {31'h0, srun});
      apb(1'b1, 12'h00c, 32'h1208);
      chk("osc run", 32'h1, {31'h0, srun});
      aux_on(1'b1);
      apb(1'b1, 12'h00c, 32'h0208);
      chk("osc run", 32'h0, {31'h0, srun});
      sreq <= 1'b1;
      @(posedge clk);
      chk("osc run", 32'h1, {31'h0, srun});
      sreq <= 1'b0;
      apb(1'b1, 12'h008, 32'h7800);
      apb(1'b1, 12'h008, 32'h9a00);
      apb(1'b1, 12'h008, 32'h0300);
      apb(1'b1, 12'h008, 32'h0046);
      apb(1'b1, 12'h008, 32'h0057);
      apb(1'b1, 12'h008, 32'h0001);
      @(posedge clk);
      chk("new source", 32'h3, {29'h0, nsrc});
      chk("go pulses", 32'h1, go_count);
      end_of_test;
   end
endmodule
